// ==== rtl/timer_defs.vh ====
`ifndef TIMER_DEFS_VH
`define TIMER_DEFS_VH
// register byte offsets
`define OFS_CONTROL   12'h000
`define OFS_CMP_A     12'h004
`define OFS_CMP_P     12'h008
`define OFS_COUNT     12'h00c
`define OFS_STATUS    12'h010
// control field positions
`define CTL_CLEAR_SEL 0
`define CTL_SWAP      1
`define CTL_INVERT    2
`define CTL_LEVEL     3
`define CTL_ACT_LO    4
`define CTL_ACT_HI    5
`define CTL_MODE_LO   6
`define CTL_MODE_HI   7
`define CTL_RUN       8
`define CTL_WIDTH     9
`define CTL_RESET     9'h000
// modes
`define MODE_COMPARE  2'h0
`define MODE_CAPTURE  2'h1
`define MODE_PWM      2'h2
`define MODE_TIMER    2'h3
// pin actions
`define ACT_NONE      2'h0
`define ACT_LOW       2'h1
`define ACT_HIGH      2'h2
`define ACT_TOGGLE    2'h3
// status bits
`define STS_MATCH_A   0
`define STS_MATCH_P   1
`define CNT_MAX       16'hffff
`endif

// ==== rtl/pin_sync.v ====
`timescale 1ns/1ps
// three-stage synchroniser, change accepted when stages 2 and 3 agree
module pin_sync (
    input  wire clk_sys,
    input  wire reset,
    input  wire clkEn,
    input  wire pinIn,
    output reg  pinLevel_q,
    output wire rise
);
    reg s1_q;
    reg s2_q;
    reg s3_q;
    reg prevLevel_q;

    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            s1_q        <= 1'b0;
            s2_q        <= 1'b0;
            s3_q        <= 1'b0;
            pinLevel_q  <= 1'b0;
            prevLevel_q <= 1'b0;
        end else if (clkEn) begin
            s1_q        <= pinIn;
            s2_q        <= s1_q;
            s3_q        <= s2_q;
            prevLevel_q <= pinLevel_q;
            if (s2_q == s3_q) begin
                pinLevel_q <= s3_q;
            end
        end
    end

    assign rise = pinLevel_q & ~prevLevel_q;
endmodule

// ==== rtl/apb_regs.v ====
`timescale 1ns/1ps
// apb slave: control, compare values, readback; zero wait states
module apb_regs (
    input  wire        clk_sys,
    input  wire        reset,
    input  wire        clkEn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        hwStop,
    input  wire        hwStart,
    input  wire [15:0] count,
    input  wire        flagA,
    input  wire        flagP,
    output reg  [8:0]  ctrl_q,
    output reg  [15:0] cmpA_q,
    output reg  [7:0]  cmpP_q,
    output wire        clrA,
    output wire        clrP
);
    `include "timer_defs.vh"

    reg  [31:0] rdMux;
    wire access = psel & penable & clkEn;
    wire wr     = access & pwrite;
    wire hit    = (paddr == `OFS_CONTROL) || (paddr == `OFS_CMP_A) ||
                  (paddr == `OFS_CMP_P) || (paddr == `OFS_COUNT) ||
                  (paddr == `OFS_STATUS);

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit;
    // write one to clear match flags
    assign clrA = wr && paddr == `OFS_STATUS && pwdata[`STS_MATCH_A];
    assign clrP = wr && paddr == `OFS_STATUS && pwdata[`STS_MATCH_P];

    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ctrl_q <= `CTL_RESET;
            cmpA_q <= 16'h0000;
            cmpP_q <= 8'h00;
            prdata <= 32'h00000000;
        end else if (clkEn) begin
            // read data captured in setup, stands through access
            if (psel && !penable) begin
                prdata <= rdMux;
            end
            if (wr && paddr == `OFS_CONTROL) begin
                ctrl_q <= pwdata[8:0];
            end else if (hwStop) begin
                ctrl_q[`CTL_RUN] <= 1'b0;
            end else if (hwStart) begin
                ctrl_q[`CTL_RUN] <= 1'b1;
            end
            if (wr && paddr == `OFS_CMP_A) begin
                cmpA_q <= pwdata[15:0];
            end
            if (wr && paddr == `OFS_CMP_P) begin
                cmpP_q <= pwdata[7:0];
            end
        end
    end

    always @* begin
        rdMux = 32'h00000000;
        if (paddr == `OFS_CONTROL) begin
            rdMux = {23'h0, ctrl_q};
        end else if (paddr == `OFS_CMP_A) begin
            rdMux = {16'h0000, cmpA_q};
        end else if (paddr == `OFS_CMP_P) begin
            rdMux = {24'h000000, cmpP_q};
        end else if (paddr == `OFS_COUNT) begin
            rdMux = {16'h0000, count};
        end else if (paddr == `OFS_STATUS) begin
            rdMux = {30'h0, flagP, flagA};
        end
    end
endmodule

// ==== rtl/timer_compare_pwm.v ====
`timescale 1ns/1ps
// Behaviour
// - mode 00 is compare-match output; clear by overflow, A or P match
// - clear select low: P match clears, P value zero lets counter wrap
// - clear select low in compare mode: both A and P flags raised
// - clear select high: A match clears, only A flag raised
// - compare A zero with clear select high: counter runs to ffff, no A flag
// - compare mode: pin changes only on A match or run rise, P ignored
// - pin action: none, low, high or toggle on A match
// - compare mode: run rising edge loads pin with initial level
// - mode 11 counts like compare mode, pin unused
// - pwm swap 0: P clears, period P*256 or 65536; A sets duty
// - duty at or above period holds output active whole period
// - pwm swap 1: A clears and sets period; duty P*256 or 65536
// - pwm ignores clear select, raises both flags
// - pwm counting continues with action 00 or 01
// - pwm action 00 forces inactive, 01 active; level bit sets active
// - invert bit inverts the output pin
// - single pulse: trigger pin rise sets run while stopped; run rise starts counter and pulse
// - single pulse: A match clears run, ends pulse, raises A flag
// - single pulse: counter zeroed only on run rise; P ignored
module timer_compare_pwm (
    input  wire        clk_sys,
    input  wire        reset,
    input  wire        clkEn,
    input  wire        timerTick,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        external_trigger_pin,
    output reg         timer_output_pin_0,
    output wire        timerOutEnable,
    output wire        matchEvent
);
    `include "timer_defs.vh"

    wire [8:0]  ctrl;
    wire [15:0] cmpA;
    wire [7:0]  cmpP;
    wire        clrA;
    wire        clrP;
    wire        trigRise;
    reg  [15:0] count_q;
    reg  [15:0] count_d;
    reg         match_a_flag_q;
    reg         match_p_flag_q;
    reg         runPrev_q;
    reg         pinRaw_q;
    reg         pinRaw_d;
    reg         hwStop;
    reg         hwStart;
    reg         setA;
    reg         setP;

    wire [1:0] mode   = {ctrl[`CTL_MODE_HI], ctrl[`CTL_MODE_LO]};
    wire [1:0] action = {ctrl[`CTL_ACT_HI], ctrl[`CTL_ACT_LO]};
    wire counter_run         = ctrl[`CTL_RUN];
    wire clear_source_select = ctrl[`CTL_CLEAR_SEL];
    wire period_duty_swap    = ctrl[`CTL_SWAP];
    wire output_invert       = ctrl[`CTL_INVERT];
    wire output_level_ctrl   = ctrl[`CTL_LEVEL];
    wire pulseMode = (mode == `MODE_PWM) && (action == `ACT_TOGGLE);
    wire pwmMode   = (mode == `MODE_PWM) && !pulseMode;
    wire runRise   = counter_run & ~runPrev_q;

    apb_regs regs (
        .clk_sys (clk_sys),
        .reset   (reset),
        .clkEn   (clkEn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .hwStop  (hwStop),
        .hwStart (hwStart),
        .count   (count_q),
        .flagA   (match_a_flag_q),
        .flagP   (match_p_flag_q),
        .ctrl_q  (ctrl),
        .cmpA_q  (cmpA),
        .cmpP_q  (cmpP),
        .clrA    (clrA),
        .clrP    (clrP)
    );

    pin_sync trig (
        .clk_sys    (clk_sys),
        .reset      (reset),
        .clkEn      (clkEn),
        .pinIn      (external_trigger_pin),
        .pinLevel_q (),
        .rise       (trigRise)
    );

    // comparators see the next count, so a clear gives an exact period
    wire [15:0] countNext = count_q + 16'h0001;
    wire matchA = (countNext == cmpA) && (cmpA != 16'h0000);
    wire matchP = (countNext[15:8] == cmpP) && (cmpP != 8'h00) &&
                  (countNext[7:0] == 8'h00);
    wire atMax  = (count_q == `CNT_MAX);
    // duty compare for pwm
    wire [16:0] periodP = (cmpP == 8'h00) ? 17'h10000 : {1'b0, cmpP, 8'h00};
    wire [16:0] dutyVal = period_duty_swap ? periodP : {1'b0, cmpA};
    wire [16:0] perVal  = period_duty_swap ? {1'b0, cmpA} : periodP;
    wire pwmActive = ({1'b0, count_q} < dutyVal) ||
                     (dutyVal >= perVal);

    // counting, clearing, flag and stop events
    always @* begin
        count_d = count_q;
        setA    = 1'b0;
        setP    = 1'b0;
        hwStop  = 1'b0;
        hwStart = 1'b0;
        if (pulseMode && trigRise && !counter_run) begin
            hwStart = 1'b1;
        end
        if (runRise) begin
            count_d = 16'h0000;
        end else if (counter_run && timerTick) begin
            count_d = countNext;
            if (mode == `MODE_COMPARE || mode == `MODE_TIMER) begin
                setA = matchA;
                if (clear_source_select) begin
                    if (matchA || atMax) begin
                        count_d = 16'h0000;
                    end
                end else begin
                    setP = matchP;
                    if (matchP || atMax) begin
                        count_d = 16'h0000;
                    end
                end
            end else if (pwmMode) begin
                setA = matchA;
                setP = matchP;
                if (period_duty_swap ? matchA : matchP) begin
                    count_d = 16'h0000;
                end
            end else if (pulseMode) begin
                setA = matchA;
                if (matchA) begin
                    hwStop = 1'b1;
                end
            end
        end
    end

    // pin level before polarity
    always @* begin
        pinRaw_d = pinRaw_q;
        if (mode == `MODE_COMPARE) begin
            if (runRise) begin
                pinRaw_d = output_level_ctrl;
            end else if (setA) begin
                case (action)
                    `ACT_LOW:    pinRaw_d = 1'b0;
                    `ACT_HIGH:   pinRaw_d = 1'b1;
                    `ACT_TOGGLE: pinRaw_d = ~pinRaw_q;
                    default:     pinRaw_d = pinRaw_q;
                endcase
            end
        end else if (pwmMode) begin
            case (action)
                `ACT_NONE: pinRaw_d = ~output_level_ctrl;
                `ACT_LOW:  pinRaw_d = output_level_ctrl;
                default:   pinRaw_d = counter_run &&
                           pwmActive ? output_level_ctrl
                                     : ~output_level_ctrl;
            endcase
        end else if (pulseMode) begin
            pinRaw_d = (counter_run && !hwStop) ? output_level_ctrl
                                                : ~output_level_ctrl;
        end
    end

    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            count_q            <= 16'h0000;
            match_a_flag_q     <= 1'b0;
            match_p_flag_q     <= 1'b0;
            runPrev_q          <= 1'b0;
            pinRaw_q           <= 1'b0;
            timer_output_pin_0 <= 1'b0;
        end else if (clkEn) begin
            count_q        <= count_d;
            runPrev_q      <= counter_run;
            // set wins over clear
            match_a_flag_q <= setA | (match_a_flag_q & ~clrA);
            match_p_flag_q <= setP | (match_p_flag_q & ~clrP);
            pinRaw_q       <= pinRaw_d;
            timer_output_pin_0 <= pinRaw_d ^ output_invert;
        end
    end

    assign timerOutEnable = (mode != `MODE_TIMER) &&
                            (mode != `MODE_CAPTURE);
    assign matchEvent = setA | setP;
endmodule

// ==== testbench/timer_monitor.sv ====
`timescale 1ns/1ps
`include "timer_defs.vh"
module timer_monitor (
    input wire        clk_sys,
    input wire        reset,
    input wire        clkEn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        timer_output_pin_0,
    input wire        timerOutEnable,
    input wire        matchEvent
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    reg  [1:0] mode_q, act_q, age_q;
    reg        lvl_q, inv_q, run_q;
    wire       pin = timer_output_pin_0;
    wire       wrCtl = clkEn & psel & penable & pwrite
                       & (paddr == `OFS_CONTROL);
    // shadow of control fields, age since last control write
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            mode_q <= 2'h0;
            act_q  <= 2'h0;
            lvl_q  <= 1'h0;
            inv_q  <= 1'h0;
            run_q  <= 1'h0;
            age_q  <= 2'h0;
        end else if (wrCtl) begin
            mode_q <= pwdata[7:6];
            act_q  <= pwdata[5:4];
            lvl_q  <= pwdata[3];
            inv_q  <= pwdata[2];
            run_q  <= pwdata[8];
            age_q  <= 2'h0;
        end else if (age_q != 2'h3) begin
            age_q  <= age_q + 2'h1;
        end
    end
    property p_unused; mode_q == 2'h3 |-> !timerOutEnable; endproperty
    a_unused: assert property (p_unused)
        else $error("pin driven in timer mode");
    property p_drives; mode_q == 2'h0 |-> timerOutEnable; endproperty
    a_drives: assert property (p_drives)
        else $error("pin not driven in compare mode");
    property p_init;
        mode_q == 2'h0 && $rose(run_q) |=> ##1 pin == (lvl_q ^ inv_q);
    endproperty
    a_init: assert property (p_init)
        else $error("pin not at initial level");
    property p_none;
        age_q == 2'h3 && mode_q == 2'h0 && act_q == 2'h0 |=> $stable(pin);
    endproperty
    a_none: assert property (p_none)
        else $error("pin moved with no action");
    property p_high;
        age_q == 2'h3 && mode_q == 2'h0 && act_q == 2'h2 && !inv_q && pin
            |=> pin;
    endproperty
    a_high: assert property (p_high)
        else $error("pin left high level");
    property p_onMatch;
        age_q == 2'h3 && mode_q == 2'h0 && pin != $past(pin)
            |-> $past(matchEvent) || $past(matchEvent, 2);
    endproperty
    a_onMatch: assert property (p_onMatch)
        else $error("pin changed without match");
    property p_off;
        age_q == 2'h3 && mode_q == 2'h2 && act_q == 2'h0
            |-> pin == (!lvl_q ^ inv_q);
    endproperty
    a_off: assert property (p_off)
        else $error("forced inactive level wrong");
    property p_on;
        age_q == 2'h3 && mode_q == 2'h2 && act_q == 2'h1
            |-> pin == (lvl_q ^ inv_q);
    endproperty
    a_on: assert property (p_on)
        else $error("forced active level wrong");
    c_pwm: cover property (mode_q == 2'h2 && matchEvent);
    c_start: cover property (mode_q == 2'h0 && $rose(run_q));
    c_pulse: cover property (wrCtl && pwdata[7:4] == 4'hb);
endmodule
bind timer_compare_pwm timer_monitor i_mon (
    .clk_sys            (clk_sys),
    .reset              (reset),
    .clkEn              (clkEn),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .timer_output_pin_0 (timer_output_pin_0),
    .timerOutEnable     (timerOutEnable),
    .matchEvent         (matchEvent)
);

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
`include "timer_defs.vh"
module testbench;
    reg         clk_sys, reset, psel, penable, pwrite, trig, tick;
    reg  [11:0] paddr;
    reg  [31:0] pwdata;
    wire [31:0] prdata;
    wire        pready, pin, outEn, slvErr;
    int         err_total, n_compared, cycles, hi, i;
    logic [31:0] rd, rd2;
    logic        rdErr;
    logic [8:0]  ct [6] = '{9'h0a9, 9'h0a8, 9'h0aa, 9'h0ac, 9'h088, 9'h098};
    logic [15:0] ca [6] = '{16'h40, 16'h200, 16'h300, 16'h40, 16'h40, 16'h40};
    int          win [6] = '{512, 512, 768, 512, 256, 256};
    int          ex [6] = '{128, 512, 256, 384, 0, 256};
    timer_compare_pwm i_dut (.clk_sys(clk_sys), .reset(reset),
        .clkEn(1'h1), .timerTick(tick), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(slvErr), .external_trigger_pin(trig),
        .timer_output_pin_0(pin), .timerOutEnable(outEn), .matchEvent());
    initial begin
        clk_sys = 1'h0;
        forever #25 clk_sys = ~clk_sys;
    end
    task report_and_stop;
        $display("compared %0d errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 12000) begin
            err_total++;
            report_and_stop;
        end
    end
    task check(input string what, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys) penable <= 1'h1;
        do @(posedge clk_sys); while (pready !== 1'h1);
        rd = prdata;
        rdErr = slvErr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk_sys);
    endtask
    task cfg(input logic [8:0] c, input logic [15:0] a, input logic [7:0] p);
        apb(1'h1, `OFS_CONTROL, 32'h0);
        apb(1'h1, `OFS_CONTROL, {23'h0, c});
        apb(1'h1, `OFS_CMP_A, {16'h0, a});
        apb(1'h1, `OFS_CMP_P, {24'h0, p});
        apb(1'h1, `OFS_STATUS, 32'h3);
        apb(1'h1, `OFS_CONTROL, {23'h0, 1'h1, c[7:0]});
    endtask
    task measure(input int n);
        hi = 0;
        repeat (n) begin
            @(posedge clk_sys);
            hi += (pin === 1'h1);
        end
    endtask
    initial begin
        reset = 1'h1;
        {psel, penable, pwrite, trig, paddr, pwdata} = '0;
        tick = 1'h1;
        repeat (16) @(posedge clk_sys);
        reset <= 1'h0;
        for (i = 0; i < 6; i++) begin
            apb(1'h0, 12'(i * 4), 32'h0);
            check("reset value", rd, 32'h0);
        end
        check("unmapped error", rdErr, 32'h1);
        // compare mode, clear on P, then clear on A
        cfg(9'h020, 16'h0010, 8'h01);
        repeat (300) @(posedge clk_sys);
        apb(1'h0, `OFS_STATUS, 32'h0);
        check("flags clear on P", rd, 32'h3);
        check("pin after A match", pin, 32'h1);
        check("pin enable", outEn, 32'h1);
        cfg(9'h021, 16'h0100, 8'h01);
        repeat (600) @(posedge clk_sys);
        apb(1'h0, `OFS_STATUS, 32'h0);
        check("flags clear on A", rd, 32'h1);
        apb(1'h1, `OFS_CONTROL, 32'h021);
        apb(1'h1, `OFS_CONTROL, 32'h121);
        repeat (2) @(posedge clk_sys);
        check("pin restart", pin, 32'h0);
        // timer mode, compare A zero
        cfg(9'h0c0, 16'h0000, 8'h01);
        apb(1'h0, `OFS_COUNT, 32'h0);
        rd2 = rd;
        apb(1'h0, `OFS_COUNT, 32'h0);
        check("count running", rd - rd2, 32'h3);
        tick <= 1'h0;
        apb(1'h0, `OFS_COUNT, 32'h0);
        rd2 = rd;
        apb(1'h0, `OFS_COUNT, 32'h0);
        check("count no tick", rd, rd2);
        tick <= 1'h1;
        repeat (600) @(posedge clk_sys);
        apb(1'h0, `OFS_STATUS, 32'h0);
        check("flags A zero", rd, 32'h2);
        check("pin enable", outEn, 32'h0);
        apb(1'h1, `OFS_CONTROL, 32'h0c0);
        apb(1'h0, `OFS_COUNT, 32'h0);
        rd2 = rd;
        apb(1'h0, `OFS_COUNT, 32'h0);
        check("count held", rd, rd2);
        // pwm table: period, duty, swap, invert, forced levels
        for (i = 0; i < 6; i++) begin
            cfg(ct[i], ca[i], 8'h01);
            repeat (16) @(posedge clk_sys);
            measure(win[i]);
            check("pwm high cycles", hi, ex[i]);
            apb(1'h0, `OFS_STATUS, 32'h0);
            if (i == 4) check("pwm flags", rd, 32'h3);
        end
        // single pulse by software, then by trigger pin
        cfg(9'h0b8, 16'h0020, 8'h05);
        measure(100);
        check("pulse width", hi, 32'd32);
        apb(1'h0, `OFS_CONTROL, 32'h0);
        check("run cleared", rd[8], 32'h0);
        trig <= 1'h1;
        measure(100);
        trig <= 1'h0;
        check("trigger pulse", hi, 32'd32);
        report_and_stop;
    end
endmodule
